/* File: common/calib_ctrl_pkg.sv */
package calib_ctrl_pkg;

  // Register byte addresses (printed offsets are not all multiples of four, so index * 4)
  localparam logic [7:0]  IDX_RUN_CONTROL  = 8'h61;
  localparam logic [7:0]  IDX_CONFIG_A     = 8'h62;
  localparam logic [7:0]  IDX_CONFIG_B     = 8'h65;
  localparam logic [7:0]  IDX_CALIB_STATUS = 8'h6A;
  localparam logic [11:0] ADDR_RUN_CONTROL  = {2'b00, IDX_RUN_CONTROL, 2'b00};
  localparam logic [11:0] ADDR_CONFIG_A     = {2'b00, IDX_CONFIG_A, 2'b00};
  localparam logic [11:0] ADDR_CONFIG_B     = {2'b00, IDX_CONFIG_B, 2'b00};
  localparam logic [11:0] ADDR_CALIB_STATUS = {2'b00, IDX_CALIB_STATUS, 2'b00};

  // Reset values
  localparam logic [7:0] RST_RUN_CONTROL = 8'h01;
  localparam logic [7:0] RST_CONFIG_A    = 8'h01;
  localparam logic [7:0] RST_CONFIG_B    = 8'h01;

  // Field positions
  localparam int BIT_CALIB_RUN     = 0;
  localparam int BIT_FG_ON         = 0;
  localparam int BIT_BG_ON         = 1;
  localparam int BIT_FG_OFFSET_ON  = 2;
  localparam int BIT_BG_OFFSET_ON  = 3;
  localparam int BIT_OFFSET_REF    = 2;
  localparam int BIT_FG_COMPLETE   = 0;

  // Timing: length of the value clear and of a foreground pass
  localparam int CLEAR_TIME_NS   = 100;
  localparam int FG_TIME_NS      = 1000;
  localparam int CLK_PERIOD_NS   = 10;
  localparam logic [15:0] CLEAR_CYCLES = 16'((CLEAR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] FG_CYCLES    = 16'((FG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Engine states
  typedef enum logic [4:0] {
    ST_HOLD  = 5'b0_0001,
    ST_CLEAR = 5'b0_0010,
    ST_FG    = 5'b0_0100,
    ST_BG    = 5'b0_1000,
    ST_IDLE  = 5'b1_0000
  } engine_state_e;

  // Configuration captured at release
  typedef struct packed {
    logic fg_on;
    logic bg_on;
    logic fg_offset_on;
    logic bg_offset_on;
    logic offset_ref_spare;
  } calib_cfg_s;

  // Engine control outputs
  typedef struct packed {
    logic engine_reset;
    logic divider_reset;
    logic clear_values;
    logic fg_active;
    logic fg_offset_active;
    logic bg_active;
    logic bg_offset_active;
    logic offset_ref_spare;
  } engine_ctrl_s;

endpackage

/* File: dv/calib_ctrl_chk.sv */
`timescale 1ns/1ps
module calib_ctrl_chk
  import calib_ctrl_pkg::*;
(
  // Bus and engine
  input wire logic         clk_sys_i,
  input wire logic         resetn_i,
  input wire logic         psel_i,
  input wire logic         penable_i,
  input wire logic         pwrite_i,
  input wire logic [11:0]  paddr_i,
  input wire logic [31:0]  pwdata_i,
  input wire logic [3:0]   pstrb_i,
  input wire logic         pready_o,
  input wire engine_ctrl_s engine_ctrl_o,
  input wire logic         fg_complete_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  // Run bit cleared by a completed write
  wire run_clr = psel_i && penable_i && pready_o && pwrite_i && paddr_i == ADDR_RUN_CONTROL && pstrb_i[0] && !pwdata_i[0];
  wire engine_ctrl_s ctl = engine_ctrl_o;
  // Run bit as last written over the bus, for the divider check
  logic run_bit_q;
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      run_bit_q <= RST_RUN_CONTROL[BIT_CALIB_RUN];
    end else if (psel_i && penable_i && pready_o && pwrite_i && paddr_i == ADDR_RUN_CONTROL && pstrb_i[0]) begin
      run_bit_q <= pwdata_i[BIT_CALIB_RUN];
    end
  end
  run_hold_a: assert property (run_clr |=> ctl.engine_reset && ctl.divider_reset) else $error("run clear no hold");
  div_follow_a: assert property (!run_bit_q |-> ctl.divider_reset && ctl.engine_reset)
    else $error("divider free while run low");
  hold_quiet_a: assert property (ctl.engine_reset |-> !(ctl.clear_values || ctl.fg_active || ctl.bg_active))
    else $error("engine busy in hold");
  bg_trim_a: assert property (ctl.bg_offset_active |-> ctl.bg_active) else $error("bg trim alone");
  fg_trim_a: assert property (ctl.fg_offset_active |-> ctl.fg_active) else $error("fg trim alone");
  clear_first_a: assert property ($rose(ctl.fg_active) |-> $past(ctl.clear_values)) else $error("fg before clear");
  done_flag_a: assert property ($rose(fg_complete_o) |-> $past(ctl.fg_active || ctl.clear_values))
    else $error("done flag early");
  cfg_latch_a: assert property ($changed(ctl.offset_ref_spare) |-> ctl.clear_values || ctl.engine_reset
    || $past(ctl.engine_reset) || $past(ctl.clear_values)) else $error("ref changed mid run");
endmodule
bind calib_ctrl calib_ctrl_chk calib_ctrl_chk_inst (.*);

/* File: dv/calib_ctrl_tb_top.sv */
`timescale 1ns/1ps
module calib_ctrl_tb_top;
  import calib_ctrl_pkg::*;
  logic         clk_sys_i, resetn_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, fg_complete_o, err;
  logic [11:0]  paddr_i;
  logic [31:0]  pwdata_i, prdata_o, rdat;
  logic [3:0]   pstrb_i;
  engine_ctrl_s engine_ctrl_o;
  int           mismatches = 0, check_count = 0, cyc = 0;
  calib_ctrl calib_ctrl_inst (.*);
  // Free running clock
  initial begin
    clk_sys_i = 0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Hang guard, far above the few hundred cycles needed
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      complete_run();
    end
  end
  // One APB transfer; request held until pready is sampled
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    psel_i <= 1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1;
    do @(posedge clk_sys_i); while (pready_o !== 1'b1);
    rdat = prdata_o;
    err = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
  endtask
  task automatic rd(input string n, input logic [11:0] a, input logic [7:0] e);
    apb(0, a, 32'h0000_0000);
    chk(n, {24'h00_0000, e}, rdat);
  endtask
  // Bounded wait for the foreground-complete flag
  task automatic wait_done();
    for (int n = 0; n < 400 && fg_complete_o !== 1'b1; n++)
      @(posedge clk_sys_i);
    #1;
  endtask
  task automatic t_reset();
    rd("run", ADDR_RUN_CONTROL, 8'h01);
    rd("cfga", ADDR_CONFIG_A, 8'h01);
    rd("cfgb", ADDR_CONFIG_B, 8'h01);
    chk("cfgb err", 32'h0000_0000, 32'(err));
    rd("unmapped", 12'h000, 8'h00);
    chk("unmapped err", 32'h0000_0001, 32'(err));
    apb(1, ADDR_CALIB_STATUS, 32'h0000_0000);
    chk("status wr err", 32'h0000_0001, 32'(err));
    wait_done();
    rd("status", ADDR_CALIB_STATUS, 8'h01);
  endtask
  task automatic t_hold();
    apb(1, ADDR_RUN_CONTROL, 32'h0000_0000); // Link never enabled here
    @(posedge clk_sys_i);
    #1;
    chk("hold", 32'h0000_0006, 32'({engine_ctrl_o.engine_reset, engine_ctrl_o.divider_reset, fg_complete_o}));
  endtask
  task automatic t_bg();
    apb(1, ADDR_CONFIG_A, 32'h0000_000A); // Written while held
    apb(1, ADDR_CONFIG_B, 32'h0000_0005); // Spare reference with background on
    rd("cfga back", ADDR_CONFIG_A, 8'h0A);
    apb(1, ADDR_RUN_CONTROL, 32'h0000_0001);
    #1;
    chk("clearing", 32'h0000_0001, 32'(engine_ctrl_o.clear_values));
    wait_done();
    chk("bg path", 32'h0000_0107, 32'({fg_complete_o, engine_ctrl_o}));
    apb(1, ADDR_CONFIG_A, 32'h0000_0001);
    repeat (20) @(posedge clk_sys_i);
    #1;
    chk("late cfg", 32'h0000_0007, 32'(engine_ctrl_o[4:0]));
  endtask
  task automatic t_fg();
    t_hold();
    apb(1, ADDR_CONFIG_A, 32'h0000_0005); // Written while held
    apb(1, ADDR_CONFIG_B, 32'h0000_0001); // Mid-code reference
    apb(1, ADDR_RUN_CONTROL, 32'h0000_0001);
    repeat (20) @(posedge clk_sys_i);
    #1;
    chk("fg path", 32'h0000_0018, 32'(engine_ctrl_o[4:0]));
    wait_done();
    rd("fg status", ADDR_CALIB_STATUS, 8'h01);
  endtask
  // Main sequence
  initial begin
    resetn_i = 0;
    psel_i = 0;
    penable_i = 0;
    pwrite_i = 0;
    paddr_i = 12'h000;
    pwdata_i = 32'h0000_0000;
    pstrb_i = 4'hF;
    repeat (8) @(posedge clk_sys_i);
    resetn_i <= 1;
    repeat (3) @(posedge clk_sys_i);
    t_reset();
    t_hold();
    t_bg();
    t_fg();
    complete_run();
  end
endmodule

/* File: rtl/calib_ctrl.sv */
`timescale 1ns/1ps
// Operation
// (R1) Run bit high lets calibration run; low holds it in reset; resets to one.
// (R2) Run bit low also resets digital-block and serial-link clock dividers.
// (R3) Software clears run bit before changing hold-required calibration registers.
// (R4) Software sets run before link enable; clears link enable before run.
// (R5) Config A bit 3 enables background offset trim, only with background on.
// (R6) Config A bit 2 enables foreground offset trim, only with foreground on.
// (R7) Config A bit 1 enables background calibration; resets to zero.
// (R8) Always clear calibration values, then run foreground if bit 0 set.
// (R9) Offset reference zero targets mid-code; input must carry no offset.
// (R10) Offset reference one matches primaries to spare converter outputs.
// (R11) Software sets offset reference only while background calibration on.
// (R12) Reserved fields written with reset values; config B bits 1:0 are one.
// (R13) Foreground-complete flag rises once foreground finished or was skipped.
// (R14) Configuration sampled at run rising edge; later changes wait for re-release.
module calib_ctrl
  import calib_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        resetn_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Engine controls
  output engine_ctrl_s     engine_ctrl_o,
  output logic             fg_complete_o
);

  // All module state except the reset synchroniser pair in one record
  typedef struct packed {
    logic [7:0]    run_ctrl;
    logic [7:0]    cfg_a;
    logic [7:0]    cfg_b;
    calib_cfg_s    live_cfg;
    engine_state_e state;
    logic [15:0]   count;
    logic          fg_complete;
    logic          ready;
    logic          slverr;
    logic [31:0]   rdata;
    engine_ctrl_s  ctrl;
  } state_s;

  // Current and next copies of the record; reset synchroniser pair
  state_s state_reg;
  state_s state_next;
  logic   rst_meta_n;
  logic   rst_sync_n;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // Capture config fields from register images
  function automatic calib_cfg_s decode_cfg(input logic [7:0] a, input logic [7:0] b);
    calib_cfg_s c;
    c.fg_on            = a[BIT_FG_ON];
    c.bg_on            = a[BIT_BG_ON];
    // Trims gated by their parent enable [R5] [R6]
    c.fg_offset_on     = a[BIT_FG_OFFSET_ON] & a[BIT_FG_ON];
    c.bg_offset_on     = a[BIT_BG_OFFSET_ON] & a[BIT_BG_ON];
    c.offset_ref_spare = b[BIT_OFFSET_REF];
    return c;
  endfunction

  // Byte-lane merge of an 8-bit register
  function automatic logic [7:0] write_byte(input logic [7:0] old, input logic [31:0] wd, input logic [3:0] st);
    return st[0] ? wd[7:0] : old;
  endfunction

  // Terminal count test, shared by clear and foreground phases
  function automatic logic count_done(input logic [15:0] cnt);
    return cnt <= 16'h0001;
  endfunction

  // Down-count step, shared by clear and foreground phases
  function automatic logic [15:0] count_down(input logic [15:0] cnt);
    return cnt - 16'h0001;
  endfunction

  // Phase after foreground work: background if enabled, else idle [R7]
  function automatic engine_state_e after_fg(input calib_cfg_s cfg);
    return cfg.bg_on ? ST_BG : ST_IDLE;
  endfunction

  // Engine controls from the state being entered and the latched config
  function automatic engine_ctrl_s ctrl_for(input engine_state_e st, input calib_cfg_s cfg);
    engine_ctrl_s o;
    o.engine_reset     = (st == ST_HOLD); // [R1]
    o.divider_reset    = (st == ST_HOLD); // [R2]
    o.clear_values     = (st == ST_CLEAR); // [R8]
    o.fg_active        = (st == ST_FG);
    o.fg_offset_active = (st == ST_FG) & cfg.fg_offset_on; // [R6]
    o.bg_active        = (st == ST_BG); // [R7]
    o.bg_offset_active = (st == ST_BG) & cfg.bg_offset_on; // [R5]
    // Zero selects mid-code, one selects spare converter reference
    o.offset_ref_spare = cfg.offset_ref_spare; // [R9] [R10]
    return o;
  endfunction

  // Access-phase strobe, blocked while the answer stands
  logic access;
  // Live copy of the run bit
  logic run_now;

  // Next-state logic for bus, engine and outputs
  always_comb begin
    state_next        = state_reg;
    access            = psel_i & penable_i & ~state_reg.ready;
    state_next.ready  = access;
    // Responses default to success; decode overrides
    state_next.slverr = 1'b0;
    // Bus decode; one wait state keeps pready registered
    if (access) begin
      if (paddr_i == ADDR_RUN_CONTROL) begin
        if (pwrite_i) state_next.run_ctrl = write_byte(state_reg.run_ctrl, pwdata_i, pstrb_i);
        state_next.rdata = {24'h00_0000, state_reg.run_ctrl};
      end else if (paddr_i == ADDR_CONFIG_A) begin
        if (pwrite_i) state_next.cfg_a = write_byte(state_reg.cfg_a, pwdata_i, pstrb_i);
        state_next.rdata = {24'h00_0000, state_reg.cfg_a};
      end else if (paddr_i == ADDR_CONFIG_B) begin
        if (pwrite_i) state_next.cfg_b = write_byte(state_reg.cfg_b, pwdata_i, pstrb_i);
        state_next.rdata = {24'h00_0000, state_reg.cfg_b};
      end else if (paddr_i == ADDR_CALIB_STATUS) begin
        // Only the foreground-complete bit exists; the rest read zero
        state_next.slverr = pwrite_i;  // Status is read-only
        state_next.rdata  = {31'h0000_0000, state_reg.fg_complete}; // [R13]
      end else begin
        state_next.slverr = 1'b1;
        state_next.rdata  = 32'h0000_0000;
      end
    end
    run_now = state_reg.run_ctrl[BIT_CALIB_RUN];
    // Engine sequencer
    case (state_reg.state)
      ST_HOLD: begin
        // Flag cleared while held so each release reports afresh
        state_next.fg_complete = 1'b0;
        if (run_now) begin
          // Sample settings only at release [R14]
          state_next.live_cfg = decode_cfg(state_reg.cfg_a, state_reg.cfg_b);
          state_next.count    = CLEAR_CYCLES;
          state_next.state    = ST_CLEAR; // [R1]
        end
      end
      ST_CLEAR: begin
        // Values cleared regardless of foreground bit [R8]
        if (count_done(state_reg.count)) begin
          if (state_reg.live_cfg.fg_on) begin
            state_next.count = FG_CYCLES;
            state_next.state = ST_FG; // [R8]
          end else begin
            state_next.fg_complete = 1'b1; // Skipped [R13]
            state_next.state       = after_fg(state_reg.live_cfg);
          end
        end else begin
          state_next.count = count_down(state_reg.count);
        end
      end
      ST_FG: begin
        // Foreground pass timed by a down-counter
        if (count_done(state_reg.count)) begin
          state_next.fg_complete = 1'b1; // [R13]
          state_next.state       = after_fg(state_reg.live_cfg); // [R7]
        end else begin
          state_next.count = count_down(state_reg.count);
        end
      end
      ST_BG: begin
        // Background work runs until the run bit falls
        state_next.state = ST_BG;
      end
      ST_IDLE: begin
        // Nothing left to run; wait for the next hold
        state_next.state = ST_IDLE;
      end
      default: state_next.state = ST_HOLD;
    endcase
    // Clearing the run bit forces hold from any state
    if (!run_now) state_next.state = ST_HOLD; // [R1]
    // Registered engine controls follow the state being entered
    state_next.ctrl = ctrl_for(state_next.state, state_next.live_cfg);
  end

  // Single state register
  always_ff @(posedge clk_sys_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      // Registers come up at their reset values; engine held
      state_reg          <= '0;
      state_reg.run_ctrl <= RST_RUN_CONTROL;
      state_reg.cfg_a    <= RST_CONFIG_A;
      state_reg.cfg_b    <= RST_CONFIG_B;
      state_reg.state    <= ST_HOLD;
      state_reg.ctrl.engine_reset  <= 1'b1;
      state_reg.ctrl.divider_reset <= 1'b1;
    end else begin
      // Whole record advances every edge
      state_reg <= state_next;
    end
  end

  // Outputs straight from flops
  assign prdata_o      = state_reg.rdata;
  assign pready_o      = state_reg.ready;
  assign pslverr_o     = state_reg.slverr;
  assign engine_ctrl_o = state_reg.ctrl;
  assign fg_complete_o = state_reg.fg_complete;

endmodule
